// >>> pkg/fps_pkg.sv
// Constants and types for the flash pulse erase/program sequencer
// Functional notes
// - Array is 16384 words of 16 bits
// - Program writes only bytes or aligned words
// - Misaligned word write programs lower-address byte only
// - Sequencer times every pulse itself
// - Top 2k F800-FFFF is protected boot block
// - Secondary vector table directly below boot block
// - Vector maps to same low byte, page below
// - Jump entry is 4 bytes, six cycles
// - Startup pin selects bootloader or application
// - Erased location reads FF
package fps_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          WORD_ADDR_W     = 14;
    localparam int          ARRAY_WORDS     = 16384;
    localparam int          CLK_MHZ         = 250;
    localparam int          ERASE_PULSE_MS  = 100;
    localparam int          ERASE_CYC       = ERASE_PULSE_MS * 1000 * CLK_MHZ;
    localparam int          PROG_PULSE_US   = 20;
    localparam int          PROG_CYC        = PROG_PULSE_US * CLK_MHZ;
    localparam int          ERASE_MAX       = 5;
    localparam int          PROG_MAX        = 50;
    localparam logic [15:0] BOOT_BASE       = 16'hF800;
    localparam logic [15:0] FLASH_BASE      = 16'h8000;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    localparam logic [7:0]  VEC_PAGE_BELOW  = 8'hF7;
    localparam logic [7:0]  VEC_LOW_FIRST   = 8'hC0;
    localparam logic [15:0] RESET_VEC       = 16'hFFFE;
    localparam int          JMP_BYTES       = 4;
    localparam int          JMP_CPU_CYCLES  = 6;
    // Control register bit positions
    localparam int          CTL_ERAS        = 2;
    localparam int          CTL_LAT         = 1;
    localparam int          CTL_ENPE        = 0;
    localparam logic [2:0]  CTL_RESET       = 3'h0;

    typedef enum logic [3:0] {
        FPS_IDLE    = 4'b0000,
        FPS_LATCH   = 4'b0001,
        FPS_PULSE   = 4'b0010,
        FPS_UNLATCH = 4'b0011,
        FPS_VERIFY  = 4'b0100,
        FPS_DECIDE  = 4'b0101,
        FPS_FINAL   = 4'b0110,
        FPS_DONE    = 4'b0111
    } fps_state_t;

    typedef enum logic [1:0] {
        FPS_ST_NONE = 2'b00,
        FPS_ST_OK   = 2'b01,
        FPS_ST_FAIL = 2'b10,
        FPS_ST_PROT = 2'b11
    } fps_status_t;
endpackage

// >>> rtl/fps_seq.sv
// Flash pulse erase/program sequencer with boot block protection and vector remap
`timescale 1ns/1ps
module fps_seq #(
    parameter int ERASE_CYCLES = fps_pkg::ERASE_CYC
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_reset,
    // Request side
    input  wire logic                      i_erase_req,
    input  wire logic                      i_prog_req,
    input  wire logic [15:0]               i_prog_addr,
    input  wire logic [15:0]               i_prog_data,
    input  wire logic                      i_prog_word,
    input  wire logic                      i_boot_sel_pin,
    input  wire logic [15:0]               i_vec_addr,
    output logic      [15:0]               o_vec_remap,
    output logic                           o_boot_loader,
    output logic                           o_busy,
    output logic                           o_done,
    output fps_pkg::fps_status_t           o_status,
    // Array side
    output logic      [2:0]                o_pulse_ctl,
    output logic                           o_arr_wr,
    output logic      [1:0]                o_arr_be,
    output logic      [13:0]               o_arr_waddr,
    output logic      [15:0]               o_arr_wdata,
    output logic                           o_arr_rd,
    output logic      [13:0]               o_arr_raddr,
    input  wire logic [15:0]               i_arr_rdata
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_boot(input logic [15:0] a);
        in_boot = (a >= fps_pkg::BOOT_BASE);
    endfunction

    function automatic logic [15:0] vec_map(input logic [15:0] a);
        vec_map = {fps_pkg::VEC_PAGE_BELOW, a[7:0]};
    endfunction

    // ------------------------------------------------------------
    // Startup pin and vector remap
    // ------------------------------------------------------------
    logic        pin_s1_reg;
    logic        pin_s2_reg;
    logic        boot_taken_reg;

    always_ff @(posedge i_clk) begin
        pin_s1_reg <= i_boot_sel_pin;
        pin_s2_reg <= pin_s1_reg;
    end

    // Pin low selects the loader; caught once after reset release
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            boot_taken_reg <= 1'b0;
            o_boot_loader  <= 1'b0;
        end else if (!boot_taken_reg) begin
            boot_taken_reg <= 1'b1;
            o_boot_loader  <= ~pin_s2_reg;
        end
    end

    // Primary vectors redirect to the table below the block
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_vec_remap <= vec_map(fps_pkg::RESET_VEC);
        end else if (i_vec_addr[15:8] == 8'hFF && i_vec_addr[7:0] >= fps_pkg::VEC_LOW_FIRST) begin
            o_vec_remap <= vec_map({i_vec_addr[15:1], 1'b0});
        end else begin
            o_vec_remap <= i_vec_addr;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    fps_pkg::fps_state_t state_reg;
    logic        is_erase_reg;
    logic        margin_reg;
    logic [5:0]  pulses_reg;
    logic [5:0]  margin_cnt_reg;
    logic [31:0] timer_reg;
    logic [13:0] scan_reg;
    logic        bad_reg;
    logic [15:0] exp_reg;
    logic [1:0]  be_reg;
    logic [13:0] tgt_reg;

    wire logic [31:0] pulse_len = is_erase_reg ? 32'(ERASE_CYCLES) : 32'(fps_pkg::PROG_CYC);
    wire logic [5:0]  pulse_max = is_erase_reg ? 6'(fps_pkg::ERASE_MAX) : 6'(fps_pkg::PROG_MAX);
    wire logic        scan_last = !is_erase_reg || (scan_reg == 14'(fps_pkg::BOOT_BASE[14:1] - 1));
    // Erase checks bytes against FF, program compares enabled lanes
    wire logic        loc_ok    = is_erase_reg ?
        (i_arr_rdata == {fps_pkg::ERASED_BYTE, fps_pkg::ERASED_BYTE}) :
        ((!be_reg[1] || i_arr_rdata[15:8] == exp_reg[15:8]) &&
         (!be_reg[0] || i_arr_rdata[7:0] == exp_reg[7:0]));
    wire logic        req_any   = i_erase_req || i_prog_req;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg      <= fps_pkg::FPS_IDLE;
            is_erase_reg   <= 1'b0;
            margin_reg     <= 1'b0;
            pulses_reg     <= 6'h00;
            margin_cnt_reg <= 6'h00;
            timer_reg      <= 32'h0000_0000;
            scan_reg       <= 14'h0000;
            bad_reg        <= 1'b0;
            exp_reg        <= 16'h0000;
            be_reg         <= 2'h0;
            tgt_reg        <= 14'h0000;
            o_status       <= fps_pkg::FPS_ST_NONE;
            o_done         <= 1'b0;
            o_pulse_ctl    <= fps_pkg::CTL_RESET;
            o_arr_wr       <= 1'b0;
            o_arr_be       <= 2'h0;
            o_arr_waddr    <= 14'h0000;
            o_arr_wdata    <= 16'h0000;
        end else begin
            o_done   <= 1'b0;
            o_arr_wr <= 1'b0;
            case (state_reg)
                fps_pkg::FPS_IDLE: begin
                    if (req_any) begin
                        o_status     <= fps_pkg::FPS_ST_NONE;
                        is_erase_reg <= i_erase_req;
                        margin_reg   <= 1'b0;
                        pulses_reg   <= 6'h00;
                        tgt_reg      <= i_prog_addr[14:1];
                        exp_reg      <= i_prog_data;
                        // Word only when aligned, else high byte at lower address
                        if (i_erase_req) begin
                            be_reg <= 2'h3;
                        end else if (i_prog_word && !i_prog_addr[0]) begin
                            be_reg <= 2'h3;
                        end else if (i_prog_addr[0]) begin
                            be_reg <= 2'h1;
                        end else begin
                            be_reg <= 2'h2;
                        end
                        if (!i_erase_req && !i_prog_word && i_prog_addr[0]) begin
                            exp_reg <= {8'h00, i_prog_data[7:0]};
                        end else if (!i_erase_req && !i_prog_word) begin
                            exp_reg <= {i_prog_data[7:0], 8'h00};
                        end else if (!i_erase_req && i_prog_addr[0]) begin
                            // Misaligned word: only its high byte reaches the odd lane
                            exp_reg <= {8'h00, i_prog_data[15:8]};
                        end
                        if (!i_erase_req && (in_boot(i_prog_addr) ||
                            i_prog_addr < fps_pkg::FLASH_BASE)) begin
                            o_status <= fps_pkg::FPS_ST_PROT;
                            o_done   <= 1'b1;
                        end else begin
                            state_reg <= fps_pkg::FPS_LATCH;
                        end
                    end
                end
                fps_pkg::FPS_LATCH: begin
                    // Latch address/data by an array write, then raise pulse
                    o_pulse_ctl[fps_pkg::CTL_LAT]  <= 1'b1;
                    o_pulse_ctl[fps_pkg::CTL_ERAS] <= is_erase_reg;
                    o_arr_wr    <= 1'b1;
                    o_arr_be    <= be_reg;
                    o_arr_waddr <= is_erase_reg ? 14'h0000 : tgt_reg;
                    o_arr_wdata <= exp_reg;
                    timer_reg   <= pulse_len;
                    state_reg   <= fps_pkg::FPS_PULSE;
                end
                fps_pkg::FPS_PULSE: begin
                    o_pulse_ctl[fps_pkg::CTL_ENPE] <= 1'b1;
                    // Run down to zero so the enable stands the full pulse length
                    if (timer_reg == 32'h0000_0000) begin
                        o_pulse_ctl[fps_pkg::CTL_ENPE] <= 1'b0;
                        state_reg <= fps_pkg::FPS_UNLATCH;
                    end else begin
                        timer_reg <= timer_reg - 32'h0000_0001;
                    end
                end
                fps_pkg::FPS_UNLATCH: begin
                    o_pulse_ctl <= fps_pkg::CTL_RESET;
                    scan_reg    <= is_erase_reg ? 14'h0000 : tgt_reg;
                    bad_reg     <= 1'b0;
                    if (margin_reg) begin
                        margin_cnt_reg <= margin_cnt_reg - 6'h01;
                        state_reg <= (margin_cnt_reg == 6'h01) ?
                            fps_pkg::FPS_FINAL : fps_pkg::FPS_LATCH;
                    end else begin
                        pulses_reg <= pulses_reg + 6'h01;
                        state_reg  <= fps_pkg::FPS_VERIFY;
                    end
                end
                fps_pkg::FPS_VERIFY, fps_pkg::FPS_FINAL: begin
                    // One location per cycle; read issued combinationally
                    if (!loc_ok) begin
                        bad_reg <= 1'b1;
                    end
                    if (scan_last) begin
                        if (state_reg == fps_pkg::FPS_FINAL) begin
                            o_status  <= (bad_reg || !loc_ok) ?
                                fps_pkg::FPS_ST_FAIL : fps_pkg::FPS_ST_OK;
                            o_done    <= 1'b1;
                            state_reg <= fps_pkg::FPS_IDLE;
                        end else begin
                            bad_reg   <= bad_reg || !loc_ok;
                            state_reg <= fps_pkg::FPS_DECIDE;
                        end
                    end else begin
                        scan_reg <= scan_reg + 14'h0001;
                    end
                end
                fps_pkg::FPS_DECIDE: begin
                    scan_reg <= is_erase_reg ? 14'h0000 : tgt_reg;
                    if (!bad_reg || pulses_reg >= pulse_max) begin
                        margin_reg     <= 1'b1;
                        margin_cnt_reg <= pulses_reg;
                    end
                    bad_reg   <= 1'b0;
                    state_reg <= fps_pkg::FPS_LATCH;
                end
                default: begin
                    state_reg <= fps_pkg::FPS_IDLE;
                end
            endcase
        end
    end

    // Read port scans only the array below the boot block
    always_comb begin
        o_arr_rd    = (state_reg == fps_pkg::FPS_VERIFY) || (state_reg == fps_pkg::FPS_FINAL);
        o_arr_raddr = scan_reg;
        o_busy      = (state_reg != fps_pkg::FPS_IDLE);
    end
endmodule

// >>> test/fps_seq_assertions.sv
// Port assertions for the flash pulse sequencer
`timescale 1ns/1ps
module fps_seq_assertions #(
    parameter int ERASE_CYCLES = 20
) (
    input wire logic                 i_clk,
    input wire logic                 i_reset,
    input wire logic                 i_erase_req,
    input wire logic                 i_prog_req,
    input wire logic [15:0]          i_prog_addr,
    input wire logic                 i_prog_word,
    input wire logic [15:0]          i_vec_addr,
    input wire logic [15:0]          o_vec_remap,
    input wire logic                 o_busy,
    input wire logic                 o_done,
    input wire fps_pkg::fps_status_t o_status,
    input wire logic [2:0]           o_pulse_ctl,
    input wire logic                 o_arr_wr,
    input wire logic [1:0]           o_arr_be,
    input wire logic [13:0]          o_arr_waddr,
    input wire logic                 o_arr_rd,
    input wire logic [13:0]          o_arr_raddr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic        take;
    logic [31:0] pw_reg;
    assign take = !o_busy && !i_erase_req && i_prog_req;
    // Length of the current enable pulse
    always_ff @(posedge i_clk) begin
        if (i_reset || !o_pulse_ctl[0]) begin
            pw_reg <= 32'h0;
        end else begin
            pw_reg <= pw_reg + 32'h1;
        end
    end
    a_word_lanes:
        assert property (take && i_prog_word && !i_prog_addr[0] && i_prog_addr >= 16'h8000
            && i_prog_addr < 16'hF800 |-> ##[1:2] (o_arr_wr && o_arr_be == 2'h3))
        else $error("aligned word not written on both lanes");
    a_refuse_boot:
        assert property (take && i_prog_addr >= 16'hF800
            |-> ##[1:2] (o_done && o_status == fps_pkg::FPS_ST_PROT))
        else $error("protected request not refused");
    a_write_range:
        assert property (o_arr_wr |-> o_arr_be != 2'h0 && o_arr_waddr < 14'h3C00)
        else $error("array write outside allowed area");
    a_read_range:
        assert property (o_arr_rd |-> o_arr_raddr < 14'h3C00)
        else $error("array read outside scan area");
    a_vec_remap:
        assert property (i_vec_addr[15:6] == 10'h3FF && !i_vec_addr[0]
            |=> o_vec_remap == {8'hF7, $past(i_vec_addr[7:0])})
        else $error("vector not mapped to page below");
    a_pulse_latch:
        assert property (o_pulse_ctl[0] |-> o_pulse_ctl[1])
        else $error("pulse enable without latch");
    a_pulse_width:
        assert property ($fell(o_pulse_ctl[0]) |-> pw_reg ==
            ($past(o_pulse_ctl[2]) ? ERASE_CYCLES : fps_pkg::PROG_CYC))
        else $error("pulse length wrong");
    a_status_hold:
        assert property ($changed(o_status) |-> o_done || o_busy)
        else $error("status changed while idle");
    c_ok: cover property (o_done && o_status == fps_pkg::FPS_ST_OK);
    c_prot: cover property (o_done && o_status == fps_pkg::FPS_ST_PROT);
    c_erase: cover property ($fell(o_pulse_ctl[0]) && $past(o_pulse_ctl[2]));
endmodule

// >>> test/fps_flash_model.sv
// Behavioural flash array driven by latch, pulse and erase controls
`timescale 1ns/1ps
module fps_flash_model #(
    parameter int ERASE_NEED = 2
) (
    input  wire logic        i_clk,
    input  wire logic [2:0]  i_pulse_ctl,
    input  wire logic        i_arr_wr,
    input  wire logic [1:0]  i_arr_be,
    input  wire logic [13:0] i_arr_waddr,
    input  wire logic [15:0] i_arr_wdata,
    input  wire logic        i_arr_rd,
    input  wire logic [13:0] i_arr_raddr,
    output logic      [15:0] o_arr_rdata
);
    logic [15:0] mem [16384];
    logic [15:0] lat_d;
    logic [13:0] lat_a;
    logic [1:0]  lat_be;
    logic        en_q = 1'b0;
    int          n_erase = 0;
    // Unselected reads give inverted data, so a stale sample never matches
    assign o_arr_rdata = i_arr_rd ? mem[i_arr_raddr] : ~mem[i_arr_raddr];
    initial begin
        foreach (mem[k]) begin
            mem[k] = 16'h0000;
        end
    end
    always @(posedge i_clk) begin
        if (i_arr_wr) begin
            lat_d = i_arr_wdata;
            lat_a = i_arr_waddr;
            lat_be = i_arr_be;
        end
        if (i_pulse_ctl[0] && i_pulse_ctl[1] && !en_q) begin
            if (i_pulse_ctl[2]) begin
                n_erase++;
                // Slow to erase, so the margin count differs from one
                if (n_erase >= ERASE_NEED) begin
                    for (int k = 0; k < 16'h3C00; k++) begin
                        mem[k] = 16'hFFFF;
                    end
                end
            end else begin
                if (lat_be[1]) begin
                    mem[lat_a][15:8] = mem[lat_a][15:8] & lat_d[15:8];
                end
                if (lat_be[0]) begin
                    mem[lat_a][7:0] = mem[lat_a][7:0] & lat_d[7:0];
                end
            end
        end
        en_q = i_pulse_ctl[0];
    end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the flash pulse sequencer
`timescale 1ns/1ps
module testbench;
    localparam int ERASE_CYCLES = 20;
    logic        i_clk, i_reset, i_erase_req, i_prog_req, i_prog_word, i_boot_sel_pin;
    logic [15:0] i_prog_addr, i_prog_data, i_vec_addr, o_vec_remap, o_arr_wdata, i_arr_rdata;
    logic        o_boot_loader, o_busy, o_done, o_arr_wr, o_arr_rd, en_q = 1'b0;
    logic [2:0]  o_pulse_ctl;
    logic [1:0]  o_arr_be, last_be;
    logic [13:0] o_arr_waddr, o_arr_raddr;
    int          n_errors = 0, compares = 0, cyc = 0, n_pulse = 0, n_wr = 0, k;
    fps_pkg::fps_status_t o_status;
    fps_seq #(.ERASE_CYCLES(ERASE_CYCLES)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_erase_req(i_erase_req),
        .i_prog_req(i_prog_req), .i_prog_addr(i_prog_addr), .i_prog_data(i_prog_data),
        .i_prog_word(i_prog_word), .i_boot_sel_pin(i_boot_sel_pin), .i_vec_addr(i_vec_addr),
        .o_vec_remap(o_vec_remap), .o_boot_loader(o_boot_loader), .o_busy(o_busy),
        .o_done(o_done), .o_status(o_status), .o_pulse_ctl(o_pulse_ctl), .o_arr_wr(o_arr_wr),
        .o_arr_be(o_arr_be), .o_arr_waddr(o_arr_waddr), .o_arr_wdata(o_arr_wdata),
        .o_arr_rd(o_arr_rd), .o_arr_raddr(o_arr_raddr), .i_arr_rdata(i_arr_rdata));
    fps_flash_model #(.ERASE_NEED(2)) u_flash (
        .i_clk(i_clk), .i_pulse_ctl(o_pulse_ctl), .i_arr_wr(o_arr_wr), .i_arr_be(o_arr_be),
        .i_arr_waddr(o_arr_waddr), .i_arr_wdata(o_arr_wdata), .i_arr_rd(o_arr_rd),
        .i_arr_raddr(o_arr_raddr), .o_arr_rdata(i_arr_rdata));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        n_pulse += (o_pulse_ctl[0] && !en_q) ? 1 : 0;
        en_q = o_pulse_ctl[0];
        if (o_arr_wr) begin
            n_wr++;
            last_be = o_arr_be;
        end
        if (cyc == 100000) begin
            n_errors++;
            results();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic op(input logic er, input logic [15:0] a, d, input logic w);
        n_pulse = 0;
        n_wr = 0;
        @(posedge i_clk);
        i_erase_req <= er;
        i_prog_req <= !er;
        i_prog_addr <= a;
        i_prog_data <= d;
        i_prog_word <= w;
        @(posedge i_clk);
        i_erase_req <= 1'b0;
        i_prog_req <= 1'b0;
        #1;
        check("busy", {15'h0, o_busy}, {15'h0, er || (a >= 16'h8000 && a < 16'hF800)});
        k = 0;
        while (o_done !== 1'b1 && k < 60000) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        check("op done", {15'h0, o_done}, 16'h0001);
        check("idle at done", {15'h0, o_busy}, 16'h0000);
    endtask
    task automatic t_erase();
        op(1'b1, 16'h0000, 16'h0000, 1'b0);
        check("erase status", 16'(o_status), 16'(fps_pkg::FPS_ST_OK));
        check("erase pulses", 16'(n_pulse), 16'h0004);
        check("erased first", u_flash.mem[0], 16'hFFFF);
        check("erased last", u_flash.mem[14'h3BFF], 16'hFFFF);
        check("boot kept", u_flash.mem[14'h3C00], 16'h0000);
    endtask
    task automatic t_prog(input logic [15:0] a, d, input logic w, input logic [1:0] be,
                          input logic [15:0] exp);
        logic [15:0] off;
        off = a - 16'h8000;
        op(1'b0, a, d, w);
        check("prog status", 16'(o_status), 16'(fps_pkg::FPS_ST_OK));
        check("prog pulses", 16'(n_pulse), 16'h0002);
        check("prog lanes", {14'h0, last_be}, {14'h0, be});
        check("prog cell", u_flash.mem[off[14:1]], exp);
    endtask
    task automatic t_refuse(input logic [15:0] a);
        op(1'b0, a, 16'h0000, 1'b1);
        check("refuse status", 16'(o_status), 16'(fps_pkg::FPS_ST_PROT));
        check("refuse delay", {15'h0, k <= 2}, 16'h0001);
        check("refuse writes", 16'(n_wr), 16'h0000);
    endtask
    task automatic t_remap();
        @(posedge i_clk);
        i_vec_addr <= 16'hFFBE;
        @(posedge i_clk);
        #1;
        check("vector pass", o_vec_remap, 16'hFFBE);
        for (int v = 16'hFFC0; v <= 16'hFFFF; v += 2) begin
            @(posedge i_clk);
            i_vec_addr <= 16'(v);
            @(posedge i_clk);
            #1;
            check("vector remap", o_vec_remap, {8'hF7, 8'(v)});
        end
    endtask
    task automatic t_boot(input logic pin, exp);
        @(posedge i_clk);
        i_boot_sel_pin <= pin;
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        check("boot select", {15'h0, o_boot_loader}, {15'h0, exp});
    endtask
    initial begin
        {i_reset, i_erase_req, i_prog_req, i_prog_word, i_boot_sel_pin} = 5'h10;
        {i_prog_addr, i_prog_data, i_vec_addr} = 48'h0;
        t_boot(1'b1, 1'b0);
        t_remap();
        t_refuse(16'hF800);
        t_refuse(16'h7FFE);
        t_erase();
        t_prog(16'h8010, 16'hA55A, 1'b1, 2'h3, 16'hA55A);
        t_prog(16'h8021, 16'h003C, 1'b0, 2'h1, 16'hFF3C);
        t_prog(16'h8031, 16'h1234, 1'b1, 2'h1, 16'hFF12);
        t_boot(1'b0, 1'b1);
        results();
    end
endmodule
bind fps_seq fps_seq_assertions #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_erase_req(i_erase_req), .i_prog_req(i_prog_req),
    .i_prog_addr(i_prog_addr), .i_prog_word(i_prog_word), .i_vec_addr(i_vec_addr),
    .o_vec_remap(o_vec_remap), .o_busy(o_busy), .o_done(o_done), .o_status(o_status),
    .o_pulse_ctl(o_pulse_ctl), .o_arr_wr(o_arr_wr), .o_arr_be(o_arr_be),
    .o_arr_waddr(o_arr_waddr), .o_arr_rd(o_arr_rd), .o_arr_raddr(o_arr_raddr));
